// *** design/irq_ctrl_regs.vh ***
// Register offsets, field positions, reset values of the interrupt control registers
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

`define ADDR_EDGE_PRIO 4'h0
`define ADDR_EXT_CTRL 4'h1
`define ADDR_RST_PRIO 4'h2
`define ADDR_PFLAG_ONE 4'h3
`define ADDR_PFLAG_TWO 4'h4
`define ADDR_CORE_CTRL 4'h5
`define ADDR_PEN_ONE 4'h6
`define ADDR_PEN_TWO 4'h7
`define ADDR_PPRIO_ONE 4'h8
`define ADDR_PPRIO_TWO 4'h9
`define ADDR_VECTOR 4'ha

`define RST_EDGE_PRIO 8'hf5
`define RST_EXT_CTRL 8'hc0
`define RST_RST_PRIO 8'h00
`define RST_CORE_CTRL 8'h00
`define RST_PPRIO_ONE 8'hff
`define RST_PPRIO_TWO 8'h0f

`define MASK_EDGE_PRIO 8'hf5
`define MASK_EXT_CTRL 8'hdb
`define MASK_PFLAG_ONE 8'hcf
`define MASK_PFLAG_TWO 8'h0f

`define BIT_PULLUP_DIS 7
`define BIT_EDGE_ZERO 6
`define BIT_EDGE_ONE 5
`define BIT_EDGE_TWO 4
`define BIT_T0_PRIO 2
`define BIT_PC_PRIO 0
`define BIT_EXT_TWO_PRIO 7
`define BIT_EXT_ONE_PRIO 6
`define BIT_EXT_TWO_EN 4
`define BIT_EXT_ONE_EN 3
`define BIT_EXT_TWO_FLAG 1
`define BIT_EXT_ONE_FLAG 0
`define BIT_PRIO_EN 7
`define BIT_GIE_HIGH 7
`define BIT_GIE_LOW 6
`define BIT_T0_EN 5
`define BIT_X0_EN 4
`define BIT_PC_EN 3
`define BIT_T0_FLAG 2
`define BIT_X0_FLAG 1
`define BIT_PC_FLAG 0

`define VEC_HIGH 24'h000008
`define VEC_LOW 24'h000018

`endif

// *** design/irq_ctrl.v ***
// Interrupt flag, enable and priority registers with vector selection
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.vh"

// Operation
// - Pull-up disable overrides latches; else latch drives
// - Edge select: 1 rising, 0 falling
// - Timer-0 priority bit picks high or low
// - Port-change priority bit picks high or low
// - Unimplemented control bits read zero
// - Ext pins one, two have priority bits
// - Ext pins one, two enable bits gate request
// - Ext flags set on edge, software clears
// - Flags set regardless of any enable
// - Compatibility mode needs peripheral group enable
// - Peripheral priorities act only with priority enabled
// - Priority enable bit selects two-level operation
// - Slave port flag set on access
// - Converter flag set on conversion done
// - Receive flag follows receive buffer full
// - Transmit flag follows transmit buffer empty
// - Sync serial flag set on completion
// - Capture/compare flags set on capture or match
// - Timer-2 match and timer-1 overflow flags
// - Collision, low-voltage, timer-3 flags; upper zero
// - Priority mode vectors by level
// - Compatibility mode vectors to high address
// - Accepting clears the admitting global enable
// - Ext pin zero always high priority
module irq_ctrl (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata_ff,
  // External interrupt pins and port
  input wire [2:0] ext_irq_pin,
  input wire [7:0] port_b_latch,
  output reg [7:0] pullup_on_ff,
  // Event pulses, with serial buffer levels
  input wire timer_zero_ovf,
  input wire port_change,
  input wire slave_port_access,
  input wire converter_done,
  input wire serial_rx_full,
  input wire serial_tx_empty,
  input wire sync_serial_done,
  input wire capcomp_one_event,
  input wire capcomp_two_event,
  input wire timer_two_match,
  input wire timer_one_ovf,
  input wire bus_collision,
  input wire low_voltage,
  input wire timer_three_ovf,
  // Core handshake
  input wire irq_accept,
  output wire irq_request,
  output reg [23:0] irq_vector_ff
);

  reg [7:0] edge_prio_ff;
  reg [7:0] ext_ctrl_ff;
  reg [7:0] rst_prio_ff;
  reg [7:0] core_ctrl_ff;
  reg [7:0] pflag_one_ff;
  reg [3:0] pflag_two_ff;
  reg [7:0] pen_one_ff;
  reg [3:0] pen_two_ff;
  reg [7:0] pprio_one_ff;
  reg [3:0] pprio_two_ff;
  reg [2:0] sync_a_ff;
  reg [2:0] sync_b_ff;
  reg [2:0] sync_c_ff;
  reg [2:0] pin_ff;
  reg [7:0] nxt_pflag_one;
  reg [3:0] nxt_pflag_two;
  reg [7:0] nxt_ext_ctrl;
  reg [7:0] nxt_core_ctrl;
  reg [7:0] nxt_rdata;
  reg [23:0] nxt_vector;

  wire [2:0] edge_sel;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;
  wire [2:0] ext_edge;
  wire prio_en;
  wire [7:0] p1_set;
  wire [3:0] p2_set;
  wire [7:0] p1_act;
  wire [3:0] p2_act;
  wire [2:0] src_act;
  wire [2:0] src_high;
  wire [1:0] ext_act;
  wire [1:0] ext_high;
  wire any_high;
  wire any_low;
  wire any_compat;
  wire periph_compat;
  wire req_high;
  wire req_low;
  wire wr_edge;
  wire wr_ext;
  wire wr_core;
  wire wr_p1;
  wire wr_p2;
  wire wr_rst;
  wire wr_pen1;
  wire wr_pen2;
  wire wr_pp1;
  wire wr_pp2;

  assign wr_edge = wr_en && (addr == `ADDR_EDGE_PRIO);
  assign wr_ext = wr_en && (addr == `ADDR_EXT_CTRL);
  assign wr_core = wr_en && (addr == `ADDR_CORE_CTRL);
  assign wr_p1 = wr_en && (addr == `ADDR_PFLAG_ONE);
  assign wr_p2 = wr_en && (addr == `ADDR_PFLAG_TWO);
  assign wr_rst = wr_en && (addr == `ADDR_RST_PRIO);
  assign wr_pen1 = wr_en && (addr == `ADDR_PEN_ONE);
  assign wr_pen2 = wr_en && (addr == `ADDR_PEN_TWO);
  assign wr_pp1 = wr_en && (addr == `ADDR_PPRIO_ONE);
  assign wr_pp2 = wr_en && (addr == `ADDR_PPRIO_TWO);

  // Pin synchronisers and edge detection
  always @(posedge clk) begin
    if (!rst_b) begin
      sync_a_ff <= 3'h0;
      sync_b_ff <= 3'h0;
      sync_c_ff <= 3'h0;
      pin_ff <= 3'h0;
    end else begin
      sync_a_ff <= ext_irq_pin;
      sync_b_ff <= sync_a_ff;
      sync_c_ff <= sync_b_ff;
      pin_ff <= ((sync_b_ff == sync_c_ff) ? sync_c_ff : pin_ff);
    end
  end

  assign edge_sel = {edge_prio_ff[`BIT_EDGE_TWO], edge_prio_ff[`BIT_EDGE_ONE],
                     edge_prio_ff[`BIT_EDGE_ZERO]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_edge
      assign pin_rise[gi] = (sync_b_ff[gi] == sync_c_ff[gi]) && sync_c_ff[gi] && !pin_ff[gi];
      assign pin_fall[gi] = (sync_b_ff[gi] == sync_c_ff[gi]) && !sync_c_ff[gi] && pin_ff[gi];
      assign ext_edge[gi] = edge_sel[gi] ? pin_rise[gi] : pin_fall[gi];
    end
  endgenerate

  assign prio_en = rst_prio_ff[`BIT_PRIO_EN];

  // Peripheral set events, order matches flag register bits
  assign p1_set = {slave_port_access, converter_done, 1'b0, 1'b0, sync_serial_done,
                   capcomp_one_event, timer_two_match, timer_one_ovf};
  assign p2_set = {bus_collision, low_voltage, timer_three_ovf, capcomp_two_event};

  // Flag next values, set wins over clear
  always @* begin
    nxt_pflag_one = pflag_one_ff;
    nxt_pflag_two = pflag_two_ff;
    nxt_ext_ctrl = ext_ctrl_ff;
    nxt_core_ctrl = core_ctrl_ff;
    if (wr_p1) begin
      nxt_pflag_one = wdata & `MASK_PFLAG_ONE;
    end
    if (wr_p2) begin
      nxt_pflag_two = wdata[3:0];
    end
    nxt_pflag_one = nxt_pflag_one | p1_set;
    nxt_pflag_one[5] = serial_rx_full;
    nxt_pflag_one[4] = serial_tx_empty;
    nxt_pflag_two = nxt_pflag_two | p2_set;
    if (wr_ext) begin
      nxt_ext_ctrl = wdata & `MASK_EXT_CTRL;
    end
    nxt_ext_ctrl[`BIT_EXT_ONE_FLAG] = nxt_ext_ctrl[`BIT_EXT_ONE_FLAG] | ext_edge[1];
    nxt_ext_ctrl[`BIT_EXT_TWO_FLAG] = nxt_ext_ctrl[`BIT_EXT_TWO_FLAG] | ext_edge[2];
    if (wr_core) begin
      nxt_core_ctrl = wdata;
    end
    nxt_core_ctrl[`BIT_T0_FLAG] = nxt_core_ctrl[`BIT_T0_FLAG] | timer_zero_ovf;
    nxt_core_ctrl[`BIT_X0_FLAG] = nxt_core_ctrl[`BIT_X0_FLAG] | ext_edge[0];
    nxt_core_ctrl[`BIT_PC_FLAG] = nxt_core_ctrl[`BIT_PC_FLAG] | port_change;
    if (irq_accept) begin
      if (!prio_en || req_high) begin
        nxt_core_ctrl[`BIT_GIE_HIGH] = 1'b0;
      end else begin
        nxt_core_ctrl[`BIT_GIE_LOW] = 1'b0;
      end
    end
  end

  // Source activity and priority
  assign p1_act = pflag_one_ff & pen_one_ff;
  assign p2_act = pflag_two_ff & pen_two_ff;
  assign src_act = {core_ctrl_ff[`BIT_T0_EN] & core_ctrl_ff[`BIT_T0_FLAG],
                    core_ctrl_ff[`BIT_X0_EN] & core_ctrl_ff[`BIT_X0_FLAG],
                    core_ctrl_ff[`BIT_PC_EN] & core_ctrl_ff[`BIT_PC_FLAG]};
  assign src_high = {edge_prio_ff[`BIT_T0_PRIO], 1'b1, edge_prio_ff[`BIT_PC_PRIO]};
  assign ext_act = {ext_ctrl_ff[`BIT_EXT_TWO_EN] & ext_ctrl_ff[`BIT_EXT_TWO_FLAG],
                    ext_ctrl_ff[`BIT_EXT_ONE_EN] & ext_ctrl_ff[`BIT_EXT_ONE_FLAG]};
  assign ext_high = {ext_ctrl_ff[`BIT_EXT_TWO_PRIO], ext_ctrl_ff[`BIT_EXT_ONE_PRIO]};

  assign any_high = |(src_act & src_high) | |(ext_act & ext_high) |
                    |(p1_act & pprio_one_ff) | |(p2_act & pprio_two_ff);
  assign any_low = |(src_act & ~src_high) | |(ext_act & ~ext_high) |
                   |(p1_act & ~pprio_one_ff) | |(p2_act & ~pprio_two_ff);
  assign periph_compat = core_ctrl_ff[`BIT_GIE_LOW] & (|p1_act | |p2_act);
  assign any_compat = |src_act | |ext_act | periph_compat;

  assign req_high = prio_en ? (core_ctrl_ff[`BIT_GIE_HIGH] & any_high) :
                    (core_ctrl_ff[`BIT_GIE_HIGH] & any_compat);
  assign req_low = prio_en & core_ctrl_ff[`BIT_GIE_LOW] & any_low & !req_high;
  assign irq_request = req_high | req_low;

  always @* begin
    nxt_vector = irq_vector_ff;
    if (req_high) begin
      nxt_vector = `VEC_HIGH;
    end else if (req_low) begin
      nxt_vector = `VEC_LOW;
    end
  end

  // Read mux
  always @* begin
    case (addr)
      `ADDR_EDGE_PRIO: nxt_rdata = edge_prio_ff & `MASK_EDGE_PRIO;
      `ADDR_EXT_CTRL: nxt_rdata = ext_ctrl_ff & `MASK_EXT_CTRL;
      `ADDR_RST_PRIO: nxt_rdata = rst_prio_ff;
      `ADDR_PFLAG_ONE: nxt_rdata = pflag_one_ff;
      `ADDR_PFLAG_TWO: nxt_rdata = {4'h0, pflag_two_ff};
      `ADDR_CORE_CTRL: nxt_rdata = core_ctrl_ff;
      `ADDR_PEN_ONE: nxt_rdata = pen_one_ff;
      `ADDR_PEN_TWO: nxt_rdata = {4'h0, pen_two_ff};
      `ADDR_PPRIO_ONE: nxt_rdata = pprio_one_ff;
      `ADDR_PPRIO_TWO: nxt_rdata = {4'h0, pprio_two_ff};
      `ADDR_VECTOR: nxt_rdata = irq_vector_ff[7:0];
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Edge select and priority control
  always @(posedge clk) begin
    if (!rst_b) begin
      edge_prio_ff <= `RST_EDGE_PRIO;
    end else if (wr_edge) begin
      edge_prio_ff <= wdata & `MASK_EDGE_PRIO;
    end
  end

  // Priority enable, other bits not kept
  always @(posedge clk) begin
    if (!rst_b) begin
      rst_prio_ff <= `RST_RST_PRIO;
    end else if (wr_rst) begin
      rst_prio_ff <= {wdata[7], 7'h00};
    end
  end

  // Peripheral enables one
  always @(posedge clk) begin
    if (!rst_b) begin
      pen_one_ff <= 8'h00;
    end else if (wr_pen1) begin
      pen_one_ff <= wdata;
    end
  end

  // Peripheral enables two
  always @(posedge clk) begin
    if (!rst_b) begin
      pen_two_ff <= 4'h0;
    end else if (wr_pen2) begin
      pen_two_ff <= wdata[3:0];
    end
  end

  // Peripheral priorities one
  always @(posedge clk) begin
    if (!rst_b) begin
      pprio_one_ff <= `RST_PPRIO_ONE;
    end else if (wr_pp1) begin
      pprio_one_ff <= wdata;
    end
  end

  // Peripheral priorities two
  always @(posedge clk) begin
    if (!rst_b) begin
      pprio_two_ff <= 4'hf;
    end else if (wr_pp2) begin
      pprio_two_ff <= wdata[3:0];
    end
  end

  // External interrupt control with pin flags
  always @(posedge clk) begin
    if (!rst_b) begin
      ext_ctrl_ff <= `RST_EXT_CTRL;
    end else begin
      ext_ctrl_ff <= nxt_ext_ctrl;
    end
  end

  // Core enables and flags
  always @(posedge clk) begin
    if (!rst_b) begin
      core_ctrl_ff <= `RST_CORE_CTRL;
    end else begin
      core_ctrl_ff <= nxt_core_ctrl;
    end
  end

  // Peripheral flags one
  always @(posedge clk) begin
    if (!rst_b) begin
      pflag_one_ff <= 8'h00;
    end else begin
      pflag_one_ff <= nxt_pflag_one;
    end
  end

  // Peripheral flags two
  always @(posedge clk) begin
    if (!rst_b) begin
      pflag_two_ff <= 4'h0;
    end else begin
      pflag_two_ff <= nxt_pflag_two;
    end
  end

  // Read data, zero outside the read answer cycle
  always @(posedge clk) begin
    if (!rst_b) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= rd_en ? nxt_rdata : 8'h00;
    end
  end

  // Vector address, holds the last level requested
  always @(posedge clk) begin
    if (!rst_b) begin
      irq_vector_ff <= `VEC_HIGH;
    end else begin
      irq_vector_ff <= nxt_vector;
    end
  end

  // Port pull-ups
  always @(posedge clk) begin
    if (!rst_b) begin
      pullup_on_ff <= 8'h00;
    end else begin
      pullup_on_ff <= edge_prio_ff[`BIT_PULLUP_DIS] ? 8'h00 : port_b_latch;
    end
  end

endmodule
`default_nettype wire

// *** test/irq_ctrl_sva.sv ***
// Port-level assertions for the interrupt control registers
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.vh"
module irq_ctrl_sva (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [3:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata_ff,
  // Port, events and vector
  input wire [7:0] port_b_latch,
  input wire [7:0] pullup_on_ff,
  input wire converter_done,
  input wire serial_rx_full,
  input wire serial_tx_empty,
  input wire [23:0] irq_vector_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  pullup_follow_a: assert property ((pullup_on_ff & ~$past(port_b_latch)) == 8'h00)
    else $error("pull-up on where latch was low");
  edge_unimp_a: assert property (rd_en && addr == `ADDR_EDGE_PRIO
    |=> (rdata_ff & ~`MASK_EDGE_PRIO) == 8'h00) else $error("edge register spare bit set");
  ext_unimp_a: assert property (rd_en && addr == `ADDR_EXT_CTRL
    |=> (rdata_ff & ~`MASK_EXT_CTRL) == 8'h00) else $error("ext register spare bit set");
  flag_two_upper_a: assert property (rd_en && addr == `ADDR_PFLAG_TWO
    |=> rdata_ff[7:4] == 4'h0) else $error("flags two upper bits set");
  rx_follow_a: assert property (rd_en && addr == `ADDR_PFLAG_ONE && $past(rst_b)
    |=> rdata_ff[5] == $past(serial_rx_full, 2)) else $error("receive flag wrong");
  tx_follow_a: assert property (rd_en && addr == `ADDR_PFLAG_ONE && $past(rst_b)
    |=> rdata_ff[4] == $past(serial_tx_empty, 2)) else $error("transmit flag wrong");
  set_wins_a: assert property (wr_en && addr == `ADDR_PFLAG_ONE && converter_done
    ##1 !wr_en ##1 rd_en && addr == `ADDR_PFLAG_ONE |=> rdata_ff[6])
    else $error("converter event lost to clear");
  vec_legal_a: assert property (irq_vector_ff == `VEC_HIGH || irq_vector_ff == `VEC_LOW)
    else $error("vector not a legal address");
  vec_reset_a: assert property ($rose(rst_b) |-> irq_vector_ff == `VEC_HIGH)
    else $error("vector not high after reset");
endmodule
bind irq_ctrl irq_ctrl_sva u_sva (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en),
  .rd_en(rd_en), .rdata_ff(rdata_ff), .port_b_latch(port_b_latch),
  .pullup_on_ff(pullup_on_ff), .converter_done(converter_done),
  .serial_rx_full(serial_rx_full), .serial_tx_empty(serial_tx_empty),
  .irq_vector_ff(irq_vector_ff));
`default_nettype wire

// *** test/tb.sv ***
// Register-level testbench for the interrupt control block
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.vh"
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [2:0] pin = 3'h0;
  logic [7:0] latch = 8'h00;
  logic [12:0] ev = 13'h0000;
  logic rx = 1'b0;
  logic tx = 1'b0;
  wire [7:0] rdata_ff;
  wire [7:0] pullup_on_ff;
  wire irq_request;
  wire [23:0] vec;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] tab [0:10] = '{8'hf5, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hff, 8'h0f, 8'h08};
  irq_ctrl u_irq_ctrl (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_ff(rdata_ff), .ext_irq_pin(pin), .port_b_latch(latch),
    .pullup_on_ff(pullup_on_ff), .timer_zero_ovf(ev[0]), .port_change(ev[1]),
    .slave_port_access(ev[2]), .converter_done(ev[3]), .serial_rx_full(rx),
    .serial_tx_empty(tx), .sync_serial_done(ev[4]), .capcomp_one_event(ev[5]),
    .capcomp_two_event(ev[6]), .timer_two_match(ev[7]), .timer_one_ovf(ev[8]),
    .bus_collision(ev[9]), .low_voltage(ev[10]), .timer_three_ovf(ev[11]),
    .irq_accept(ev[12]), .irq_request(irq_request), .irq_vector_ff(vec));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write with optional event pulses in the same cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [12:0] e);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    ev <= e;
    @(posedge clk);
    wr_en <= 1'b0;
    ev <= 13'h0000;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk("rdata", {16'h0, exp}, {16'h0, rdata_ff});
  endtask
  task automatic pins(input logic [2:0] v);
    @(posedge clk);
    pin <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic idle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 11; a++) rd(a[3:0], tab[a]);
    rd(4'hf, 8'h00);
    wr(4'h0, 8'hff, 13'h0);
    rd(4'h0, 8'hf5);
    wr(4'h1, 8'hff, 13'h0);
    rd(4'h1, 8'hdb);
    wr(4'h1, 8'hc0, 13'h0);
    latch <= 8'h5a;
    idle();
    chk("pullup", 24'h0, {16'h0, pullup_on_ff});
    wr(4'h0, 8'h75, 13'h0);
    idle();
    chk("pullup", 24'h5a, {16'h0, pullup_on_ff});
    pins(3'b010);
    rd(4'h1, 8'hc1);
    wr(4'h0, 8'h65, 13'h0);
    pins(3'b110);
    rd(4'h1, 8'hc1);
    pins(3'b010);
    rd(4'h1, 8'hc3);
    pins(3'b011);
    rd(4'h5, 8'h02);
    wr(4'h1, 8'hc0, 13'h0);
    rd(4'h1, 8'hc0);
    wr(4'hf, 8'h00, 13'h0fff);
    rd(4'h3, 8'hcf);
    rd(4'h4, 8'h0f);
    rd(4'h5, 8'h07);
    wr(4'h3, 8'h00, 13'h0);
    wr(4'h4, 8'h00, 13'h0);
    wr(4'h5, 8'h00, 13'h0);
    rd(4'h4, 8'h00);
    wr(4'h3, 8'h00, 13'h0008);
    rd(4'h3, 8'h40);
    @(posedge clk);
    rx <= 1'b1;
    rd(4'h3, 8'h60);
    rx <= 1'b0;
    tx <= 1'b1;
    rd(4'h3, 8'h50);
    tx <= 1'b0;
    wr(4'h3, 8'h00, 13'h0100);
    wr(4'h6, 8'h01, 13'h0);
    wr(4'h8, 8'hfe, 13'h0);
    wr(4'h5, 8'h80, 13'h0);
    idle();
    chk("request", 24'h0, {23'h0, irq_request});
    wr(4'h5, 8'hc0, 13'h0);
    idle();
    chk("request", 24'h1, {23'h0, irq_request});
    chk("vector", `VEC_HIGH, vec);
    wr(4'hf, 8'h00, 13'h1000);
    rd(4'h5, 8'h40);
    wr(4'h2, 8'h80, 13'h0);
    idle();
    chk("vector", `VEC_LOW, vec);
    wr(4'hf, 8'h00, 13'h1000);
    rd(4'h5, 8'h00);
    wr(4'h8, 8'hff, 13'h0);
    wr(4'h5, 8'h80, 13'h0);
    idle();
    chk("vector", `VEC_HIGH, vec);
    wr(4'h6, 8'h00, 13'h0001);
    wr(4'h0, 8'h71, 13'h0);
    wr(4'h5, 8'h64, 13'h0);
    idle();
    chk("vector", `VEC_LOW, vec);
    conclude();
  end
endmodule
`default_nettype wire
